// *** uft_params.svh ***
// constants for the serial port: field codes, widths and divide figures
`ifndef UFT_PARAMS_SVH
`define UFT_PARAMS_SVH

// prescaler select codes and their divide ratios
`define UFT_PS_SEL_12 2'h0
`define UFT_PS_SEL_4 2'h1
`define UFT_PS_SEL_48 2'h2
`define UFT_PS_SEL_1 2'h3
`define UFT_PS_DIV_12 6'h0c
`define UFT_PS_DIV_4 6'h04
`define UFT_PS_DIV_48 6'h30
`define UFT_PS_DIV_1 6'h01

// baud timer wrap point
`define UFT_TIMER_MAX 16'hffff
`define UFT_RELOAD_W 16

// parity type codes
`define UFT_PAR_ODD 2'h0
`define UFT_PAR_EVEN 2'h1
`define UFT_PAR_MARK 2'h2
`define UFT_PAR_SPACE 2'h3

// data length codes: length is the least length plus the code
`define UFT_DL_5 2'h0
`define UFT_MIN_DATA_BITS 3'h5

// fifo depths
`define UFT_TX_DEPTH 8
`define UFT_RX_DEPTH 3

`endif

// *** uft_pkg.sv ***
// shared types for the serial port
package uft_pkg;

  // frame format settings
  typedef struct packed {
    logic       multidrop_filter_enable;
    logic [1:0] parity_type_select;
    logic       parity_enable;
    logic [1:0] data_length_select;
    logic       extra_bit_enable;
    logic       stop_long;
  } uft_fmt_s;

  // baud generator settings
  typedef struct packed {
    logic        run;
    logic [1:0]  baud_prescaler_select;
    logic [15:0] reload;
  } uft_baud_s;

  // sticky status flags
  typedef struct packed {
    logic overrun_flag;
    logic parity_error_flag;
    logic transmit_done_flag;
    logic receive_ready_flag;
  } uft_flags_s;

  // bit phases of a frame, shared by both directions
  typedef enum logic [2:0] {
    UFT_IDLE  = 3'b000,
    UFT_START = 3'b001,
    UFT_DATA  = 3'b010,
    UFT_EXTRA = 3'b011,
    UFT_STOP  = 3'b100
  } uft_state_e;

endpackage

// *** uft_fifo.sv ***
// small first-in first-out buffer with a registered head word
module uft_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // filling side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  // draining side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH]; // storage, written in place
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt; // next slot to fill
  logic [AW-1:0] rd_ptr_r, rd_ptr_nxt; // oldest slot
  logic [CW-1:0] cnt_r, cnt_nxt; // words held
  logic [WIDTH-1:0] head_r, head_nxt; // registered head word
  logic vld_r, vld_nxt; // head word is real
  logic push, pop;

  assign wr_ready = (cnt_r != CW'(DEPTH));
  assign push = wr_valid & wr_ready;
  assign pop = rd_ready & vld_r;
  assign rd_valid = vld_r;
  assign rd_data = head_r;
  assign count = cnt_r;

  // pointer arithmetic wraps at the depth, which need not be a power of two
  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    cnt_nxt = cnt_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
    vld_nxt = (cnt_nxt != '0);
    // a word written into the new head slot this cycle bypasses the array
    if (push && (wr_ptr_r == rd_ptr_nxt)) begin
      head_nxt = wr_data;
    end else begin
      head_nxt = vld_nxt ? mem_r[rd_ptr_nxt] : head_r;
    end
  end

  // storage has no reset; only pointers and flags need a defined value
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wr_data;
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      head_r <= '0;
      vld_r <= 1'b0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      cnt_r <= cnt_nxt;
      head_r <= head_nxt;
      vld_r <= vld_nxt;
    end
  end
endmodule

// *** uft_baud.sv ***
// baud timer: prescaler plus up-counting reload timer, one tick per wrap
`include "uft_params.svh"
module uft_baud (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // settings
  input uft_pkg::uft_baud_s cfg,
  // phase restart, reloads timer and prescaler
  input wire logic restart,
  // one pulse per timer wrap, two per bit time
  output logic tick
);
  logic [5:0] pre_r, pre_nxt; // prescaler count
  logic [15:0] tmr_r, tmr_nxt; // baud timer
  logic tick_r, tick_nxt; // wrap strobe
  logic [5:0] div; // prescale ratio

  assign tick = tick_r;

  // prescaler code to ratio
  always_comb begin
    case (cfg.baud_prescaler_select)
      `UFT_PS_SEL_12: div = `UFT_PS_DIV_12;
      `UFT_PS_SEL_4: div = `UFT_PS_DIV_4;
      `UFT_PS_SEL_48: div = `UFT_PS_DIV_48;
      `UFT_PS_SEL_1: div = `UFT_PS_DIV_1;
      default: div = `UFT_PS_DIV_1;
    endcase
  end

  // count up from reload, reload on wrap from all ones
  always_comb begin
    pre_nxt = pre_r;
    tmr_nxt = tmr_r;
    tick_nxt = 1'b0;
    if (restart || !cfg.run) begin
      pre_nxt = '0;
      tmr_nxt = cfg.reload;
    end else if (pre_r == div - 6'h01) begin
      pre_nxt = '0;
      if (tmr_r == `UFT_TIMER_MAX) begin
        tmr_nxt = cfg.reload;
        tick_nxt = 1'b1;
      end else begin
        tmr_nxt = tmr_r + 16'h0001;
      end
    end else begin
      pre_nxt = pre_r + 6'h01;
    end
  end

  // registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pre_r <= '0;
      tmr_r <= cfg.reload;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_nxt;
      tmr_r <= tmr_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

// *** uft_top.sv ***
// serial port: frame format, transmit path, receive path with fifo
`include "uft_params.svh"
module uft_top #(
  parameter int TX_DEPTH = `UFT_TX_DEPTH,
  parameter int RX_DEPTH = `UFT_RX_DEPTH
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // configuration
  input uft_pkg::uft_fmt_s fmt,
  input uft_pkg::uft_baud_s baud,
  input wire logic receive_enable_bit,
  input wire logic transmit_extra_bit,
  // transmit data, written to the buffer
  input wire logic tx_wr_valid,
  output logic tx_wr_ready,
  input wire logic [7:0] tx_wr_data,
  // receive data, read from the buffer
  input wire logic rx_rd,
  output logic rx_valid,
  output logic [7:0] serial_data_buffer,
  output logic received_extra_bit,
  // flag clears, one pulse each
  input uft_pkg::uft_flags_s flag_clr,
  // sticky flags
  output uft_pkg::uft_flags_s flags,
  // serial pins
  output logic serial_out_pin,
  input wire logic serial_in_pin
);
  // ---------------- shared format decode ----------------
  logic [3:0] nbits; // data bits per frame
  logic xbit_on; // extra bit in use
  logic two_stop; // second stop bit in use
  assign nbits = {1'b0, `UFT_MIN_DATA_BITS} + {2'b00, fmt.data_length_select};
  assign xbit_on = fmt.extra_bit_enable & ~fmt.parity_enable;
  assign two_stop = fmt.stop_long & (fmt.data_length_select != `UFT_DL_5);

  // parity bit for a data word, masked to the live length
  function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
                                   input logic [1:0] typ);
    logic [7:0] m;
    logic p;
    m = 8'hff >> (4'h8 - n);
    p = ^(d & m);
    case (typ)
      `UFT_PAR_ODD: par_bit = ~p;
      `UFT_PAR_EVEN: par_bit = p;
      `UFT_PAR_MARK: par_bit = 1'b1;
      `UFT_PAR_SPACE: par_bit = 1'b0;
      default: par_bit = p;
    endcase
  endfunction

  // ---------------- baud timers ----------------
  logic tx_tick, rx_tick, rx_restart;
  // free-running phase for sending
  uft_baud u_tx_baud (
    .sys_clk(sys_clk),
    .reset(reset),
    .cfg(baud),
    .restart(1'b0),
    .tick(tx_tick)
  );
  // receive phase restarted on each start edge, so odd wraps land mid-bit
  uft_baud u_rx_baud (
    .sys_clk(sys_clk),
    .reset(reset),
    .cfg(baud),
    .restart(rx_restart),
    .tick(rx_tick)
  );

  // ---------------- transmit fifo ----------------
  logic txf_valid, txf_pop;
  logic [7:0] txf_data;
  // software may queue ahead; ready drops when the fifo fills
  uft_fifo #(.WIDTH(8), .DEPTH(TX_DEPTH)) u_tx_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_valid(tx_wr_valid),
    .wr_ready(tx_wr_ready),
    .wr_data(tx_wr_data),
    .rd_valid(txf_valid),
    .rd_ready(txf_pop),
    .rd_data(txf_data),
    .count()
  );

  // ---------------- transmitter ----------------
  uft_pkg::uft_state_e tx_st_r, tx_st_nxt; // frame phase
  logic [7:0] tx_sh_r, tx_sh_nxt; // shifter
  logic [3:0] tx_cnt_r, tx_cnt_nxt; // bits left in phase
  logic tx_half_r, tx_half_nxt; // second half of bit
  logic tx_out_r, tx_out_nxt; // pin level
  logic tx_xb_r, tx_xb_nxt; // parity or extra bit
  logic tx_done_set; // stop time begins
  logic tx_end; // bit time ends on this tick

  assign tx_end = tx_tick & tx_half_r;
  assign txf_pop = (tx_st_r == uft_pkg::UFT_IDLE) & baud.run;
  assign serial_out_pin = tx_out_r;

  // frame sequencer, one bit per two timer wraps
  always_comb begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_half_nxt = tx_tick ? ~tx_half_r : tx_half_r;
    tx_out_nxt = tx_out_r;
    tx_xb_nxt = tx_xb_r;
    tx_done_set = 1'b0;
    case (tx_st_r)
      uft_pkg::UFT_IDLE: begin
        tx_out_nxt = 1'b1;
        if (txf_valid && baud.run) begin
          tx_sh_nxt = txf_data;
          tx_xb_nxt = fmt.parity_enable ?
            par_bit(txf_data, nbits, fmt.parity_type_select) :
            transmit_extra_bit;
          tx_st_nxt = uft_pkg::UFT_START;
          tx_out_nxt = 1'b0;
          tx_half_nxt = 1'b0;
          tx_cnt_nxt = nbits;
        end
      end
      uft_pkg::UFT_START: begin
        if (tx_end) begin
          tx_st_nxt = uft_pkg::UFT_DATA;
          tx_out_nxt = tx_sh_r[0];
          tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
        end
      end
      uft_pkg::UFT_DATA: begin
        if (tx_end) begin
          tx_cnt_nxt = tx_cnt_r - 4'h1;
          if (tx_cnt_r != 4'h1) begin
            tx_out_nxt = tx_sh_r[0];
            tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
          end else if (fmt.parity_enable || xbit_on) begin
            tx_st_nxt = uft_pkg::UFT_EXTRA;
            tx_out_nxt = tx_xb_r;
          end else begin
            tx_st_nxt = uft_pkg::UFT_STOP;
            tx_out_nxt = 1'b1;
            tx_cnt_nxt = two_stop ? 4'h2 : 4'h1;
            tx_done_set = 1'b1;
          end
        end
      end
      uft_pkg::UFT_EXTRA: begin
        if (tx_end) begin
          tx_st_nxt = uft_pkg::UFT_STOP;
          tx_out_nxt = 1'b1;
          tx_cnt_nxt = two_stop ? 4'h2 : 4'h1;
          tx_done_set = 1'b1;
        end
      end
      uft_pkg::UFT_STOP: begin
        if (tx_end) begin
          tx_cnt_nxt = tx_cnt_r - 4'h1;
          if (tx_cnt_r == 4'h1) begin
            tx_st_nxt = uft_pkg::UFT_IDLE;
          end
        end
      end
      default: tx_st_nxt = uft_pkg::UFT_IDLE;
    endcase
  end

  // transmit registers; line idles high
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      tx_st_r <= uft_pkg::UFT_IDLE;
      tx_sh_r <= '0;
      tx_cnt_r <= '0;
      tx_half_r <= 1'b0;
      tx_out_r <= 1'b1;
      tx_xb_r <= 1'b0;
    end else begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_half_r <= tx_half_nxt;
      tx_out_r <= tx_out_nxt;
      tx_xb_r <= tx_xb_nxt;
    end
  end

  // ---------------- receive pin synchroniser ----------------
  logic rx_m_r, rx_s_r, rx_p_r; // two stages, then edge history
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_m_r <= 1'b1;
      rx_s_r <= 1'b1;
      rx_p_r <= 1'b1;
    end else begin
      rx_m_r <= serial_in_pin;
      rx_s_r <= rx_m_r;
      rx_p_r <= rx_s_r;
    end
  end

  // ---------------- receiver ----------------
  uft_pkg::uft_state_e rx_st_r, rx_st_nxt; // frame phase
  logic [7:0] rx_d_r, rx_d_nxt; // assembled data
  logic [3:0] rx_cnt_r, rx_cnt_nxt; // bit index
  logic rx_half_r, rx_half_nxt; // sample on odd wrap
  logic rx_xb_r, rx_xb_nxt; // parity or extra bit
  logic rx_sb_r, rx_sb_nxt; // first stop bit level
  logic rx_stop_ok_r, rx_stop_ok_nxt; // all stops high so far
  logic rx_done; // frame finished this cycle
  logic rx_smp; // bit centre reached
  logic [8:0] rxf_wdata; // data plus extra or stop bit
  logic rxf_wvalid, rxf_wready;
  logic [8:0] rxf_rdata;
  logic [$clog2(RX_DEPTH+1)-1:0] rxf_count;
  logic store_ok; // frame may enter the fifo

  assign rx_smp = rx_tick & rx_half_r;

  // frame sequencer; the timer restarts on the falling edge
  always_comb begin
    rx_st_nxt = rx_st_r;
    rx_d_nxt = rx_d_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_half_nxt = rx_tick ? ~rx_half_r : rx_half_r;
    rx_xb_nxt = rx_xb_r;
    rx_sb_nxt = rx_sb_r;
    rx_stop_ok_nxt = rx_stop_ok_r;
    rx_restart = 1'b0;
    rx_done = 1'b0;
    case (rx_st_r)
      uft_pkg::UFT_IDLE: begin
        // falling edge while enabled opens a frame
        if (receive_enable_bit && baud.run && rx_p_r && !rx_s_r) begin
          rx_restart = 1'b1;
          rx_half_nxt = 1'b1;
          rx_st_nxt = uft_pkg::UFT_START;
          rx_d_nxt = '0;
          rx_cnt_nxt = '0;
          rx_stop_ok_nxt = 1'b1;
        end
      end
      uft_pkg::UFT_START: begin
        // first wrap is half a bit in: a glitch reads high here
        if (rx_smp) begin
          rx_half_nxt = 1'b0;
          rx_st_nxt = rx_s_r ? uft_pkg::UFT_IDLE : uft_pkg::UFT_DATA;
        end
      end
      uft_pkg::UFT_DATA: begin
        if (rx_smp) begin
          rx_d_nxt[rx_cnt_r[2:0]] = rx_s_r;
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          if (rx_cnt_r == nbits - 4'h1) begin
            rx_cnt_nxt = '0;
            rx_st_nxt = (fmt.parity_enable || xbit_on) ?
              uft_pkg::UFT_EXTRA : uft_pkg::UFT_STOP;
          end
        end
      end
      uft_pkg::UFT_EXTRA: begin
        if (rx_smp) begin
          rx_xb_nxt = rx_s_r;
          rx_st_nxt = uft_pkg::UFT_STOP;
        end
      end
      uft_pkg::UFT_STOP: begin
        if (rx_smp) begin
          if (rx_cnt_r == 4'h0) begin
            rx_sb_nxt = rx_s_r;
          end
          rx_stop_ok_nxt = rx_stop_ok_r & rx_s_r;
          rx_cnt_nxt = rx_cnt_r + 4'h1;
          // finishing at mid-stop leaves time to catch the next edge
          if (rx_cnt_r == 4'h1 || !two_stop) begin
            rx_done = 1'b1;
            rx_st_nxt = uft_pkg::UFT_IDLE;
          end
        end
      end
      default: rx_st_nxt = uft_pkg::UFT_IDLE;
    endcase
    // losing the enable abandons a frame in flight
    if (!receive_enable_bit) begin
      rx_st_nxt = uft_pkg::UFT_IDLE;
      rx_done = 1'b0;
    end
  end

  // receive registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_st_r <= uft_pkg::UFT_IDLE;
      rx_d_r <= '0;
      rx_cnt_r <= '0;
      rx_half_r <= 1'b0;
      rx_xb_r <= 1'b0;
      rx_sb_r <= 1'b1;
      rx_stop_ok_r <= 1'b1;
    end else begin
      rx_st_r <= rx_st_nxt;
      rx_d_r <= rx_d_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_half_r <= rx_half_nxt;
      rx_xb_r <= rx_xb_nxt;
      rx_sb_r <= rx_sb_nxt;
      rx_stop_ok_r <= rx_stop_ok_nxt;
    end
  end

  // frame completion: stop bits are final in the _nxt values
  assign store_ok = rx_done & rx_stop_ok_nxt;
  assign rxf_wvalid = store_ok;
  assign rxf_wdata = {xbit_on ? rx_xb_r : rx_sb_nxt, rx_d_r};

  // receive fifo; a full fifo refuses, which counts as overrun
  uft_fifo #(.WIDTH(9), .DEPTH(RX_DEPTH)) u_rx_fifo (
    .sys_clk(sys_clk),
    .reset(reset),
    .wr_valid(rxf_wvalid),
    .wr_ready(rxf_wready),
    .wr_data(rxf_wdata),
    .rd_valid(rx_valid),
    .rd_ready(rx_rd),
    .rd_data(rxf_rdata),
    .count(rxf_count)
  );
  assign serial_data_buffer = rxf_rdata[7:0];
  assign received_extra_bit = rxf_rdata[8];

  // ---------------- sticky flags ----------------
  uft_pkg::uft_flags_s flg_r, flg_nxt;
  logic stored, par_bad;
  assign stored = store_ok & rxf_wready;
  assign par_bad = rx_done & fmt.parity_enable &
    (rx_xb_r != par_bit(rx_d_r, nbits, fmt.parity_type_select));
  assign flags = flg_r;

  // a set in the same cycle as a clear wins; ready holds while more than one byte waits
  always_comb begin
    flg_nxt = flg_r;
    if (flag_clr.transmit_done_flag) flg_nxt.transmit_done_flag = 1'b0;
    if (flag_clr.overrun_flag) flg_nxt.overrun_flag = 1'b0;
    if (flag_clr.parity_error_flag) flg_nxt.parity_error_flag = 1'b0;
    // the clear cannot take while a further byte is queued behind the head
    if (flag_clr.receive_ready_flag && rxf_count <= 1) begin
      flg_nxt.receive_ready_flag = 1'b0;
    end
    if (tx_done_set) flg_nxt.transmit_done_flag = 1'b1;
    if (store_ok && !rxf_wready) flg_nxt.overrun_flag = 1'b1;
    if (par_bad) flg_nxt.parity_error_flag = 1'b1;
    // address filter: only frames whose extra bit is one raise ready
    if (stored && (!fmt.multidrop_filter_enable || rx_xb_r)) begin
      flg_nxt.receive_ready_flag = 1'b1;
    end
  end

  // flag registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flg_r <= '0;
    end else begin
      flg_r <= flg_nxt;
    end
  end
endmodule

// *** uft_chk.sv ***
// assertion checker watching the serial port's top-level ports
module uft_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // configuration and requests
  input uft_pkg::uft_fmt_s fmt,
  input wire logic receive_enable_bit,
  input wire logic rx_rd,
  input uft_pkg::uft_flags_s flag_clr,
  // outputs of the port
  input wire logic tx_wr_ready,
  input wire logic rx_valid,
  input wire logic [7:0] serial_data_buffer,
  input wire logic received_extra_bit,
  input uft_pkg::uft_flags_s flags,
  input wire logic serial_out_pin
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // out of reset the line idles high and nothing is queued
  property p_idle;
    $fell(reset) |-> serial_out_pin && !rx_valid && tx_wr_ready;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  // done flag rises only once the line sits in a stop bit
  property p_done_stop;
    $rose(flags.transmit_done_flag) |-> serial_out_pin ##1 serial_out_pin;
  endproperty
  a_done_stop: assert property (p_done_stop) else $error("done early");
  // overrun is sticky until cleared
  property p_ovr_hold;
    flags.overrun_flag && !flag_clr.overrun_flag |=> flags.overrun_flag;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("ovr lost");
  // parity error is sticky until cleared
  property p_perr_hold;
    flags.parity_error_flag && !flag_clr.parity_error_flag
      |=> flags.parity_error_flag;
  endproperty
  a_perr_hold: assert property (p_perr_hold) else $error("perr lost");
  // a parity error needs parity checking switched on
  property p_perr_cause;
    $rose(flags.parity_error_flag) |-> fmt.parity_enable;
  endproperty
  a_perr_cause: assert property (p_perr_cause) else $error("perr");
  // ready flag means a byte really sits in the buffer
  property p_rr_store;
    $rose(flags.receive_ready_flag) |-> ##[0:1] rx_valid;
  endproperty
  a_rr_store: assert property (p_rr_store) else $error("rr empty");
  // a disabled receiver stores nothing new
  property p_rx_off;
    !receive_enable_bit [*6] |-> !$rose(rx_valid);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx while off");
  // the head byte stands until it is read
  property p_head_hold;
    rx_valid && !rx_rd |=> rx_valid && $stable(serial_data_buffer)
      && $stable(received_extra_bit);
  endproperty
  a_head_hold: assert property (p_head_hold) else $error("head moved");
endmodule
bind uft_top uft_chk uft_chk_i (.sys_clk(sys_clk), .reset(reset),
  .fmt(fmt), .receive_enable_bit(receive_enable_bit), .rx_rd(rx_rd),
  .flag_clr(flag_clr), .tx_wr_ready(tx_wr_ready), .rx_valid(rx_valid),
  .serial_data_buffer(serial_data_buffer),
  .received_extra_bit(received_extra_bit), .flags(flags),
  .serial_out_pin(serial_out_pin));

// *** uft_peer.sv ***
// remote serial node model: frame sender and frame decoder
module uft_peer (
  // clock
  input wire logic sys_clk,
  // line from the port and line into it
  input wire logic line_in,
  output logic line_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int bit_len = 16; // cycles per bit, set by the bench
  initial line_out = 1'b1; // idle line sits high
  // start bit, then n bits lsb first: data, parity or extra, stops
  task automatic send(input logic [11:0] v, input int n);
    @(negedge sys_clk);
    line_out = 1'b0;
    repeat (bit_len) @(negedge sys_clk);
    for (int k = 0; k < n; k++) begin
      line_out = v[k];
      repeat (bit_len) @(negedge sys_clk);
    end
    line_out = 1'b1;
  endtask
  // syncs on the end of the start bit, so the first data bit must be one;
  // the first start bit of a burst may be short, this avoids relying on it
  task automatic recv(input int n, output logic [11:0] v, output time t);
    v = 12'hfff;
    @(negedge line_in);
    @(posedge line_in);
    t = $time;
    for (int k = 0; k < n; k++) begin
      repeat (k == 0 ? bit_len / 2 : bit_len) @(posedge sys_clk);
      v[k] = line_in;
    end
  endtask
endmodule

// *** testbench.sv ***
// self-checking bench for the serial port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, ren, txb, tx_wr_valid, tx_wr_ready, rx_rd;
  logic rx_valid, rbx, txl, rxl;
  logic [7:0] tx_wr_data, sdb;
  uft_pkg::uft_fmt_s fmt;
  uft_pkg::uft_baud_s baud;
  uft_pkg::uft_flags_s flag_clr, flags;
  int n_fail, total_checks;
  int pdiv[4] = '{12, 4, 48, 1}; // prescaler ratio per code
  logic [7:0] txf[7] = '{8'h01, 8'h15, 8'h38, 8'h7f, 8'h5c, 8'h0e, 8'h0b};
  logic [6:0] txx = 7'b0101000; // extra bit value per format
  uft_top uft_top_i (.sys_clk(sys_clk), .reset(reset), .fmt(fmt),
    .baud(baud), .receive_enable_bit(ren), .transmit_extra_bit(txb),
    .tx_wr_valid(tx_wr_valid), .tx_wr_ready(tx_wr_ready),
    .tx_wr_data(tx_wr_data), .rx_rd(rx_rd), .rx_valid(rx_valid),
    .serial_data_buffer(sdb), .received_extra_bit(rbx),
    .flag_clr(flag_clr), .flags(flags), .serial_out_pin(txl),
    .serial_in_pin(rxl));
  uft_peer uft_peer_i (.sys_clk(sys_clk), .line_in(txl), .line_out(rxl));
  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // parity of the low nd bits: odd, even, mark, space
  function automatic logic par(input logic [7:0] d, input int nd,
                               input logic [1:0] pt);
    logic x;
    x = ^(d & (8'hff >> (8 - nd)));
    return pt[1] ? ~pt[0] : (x ^ ~pt[0]);
  endfunction
  // bits after start: data, parity or extra, stops; upper bits stay one
  function automatic logic [11:0] frm(input logic [7:0] f, d,
                                      input logic b, output int n);
    int nd;
    logic [11:0] v;
    nd = 5 + int'(f[3:2]);
    n = nd;
    v = 12'hfff;
    for (int k = 0; k < nd; k++) v[k] = d[k];
    if (f[4] || f[1]) begin
      v[n] = b;
      n++;
    end
    n += (f[0] && nd > 5) ? 2 : 1;
    return v;
  endfunction
  task automatic clr();
    flag_clr = 4'hf;
    @(negedge sys_clk);
    flag_clr = 4'h0;
    @(negedge sys_clk);
  endtask
  task automatic pop(input logic [7:0] d);
    check("valid", rx_valid, 1'b1);
    check("data", sdb, d);
    rx_rd = 1'b1;
    @(negedge sys_clk);
    rx_rd = 1'b0;
    @(negedge sys_clk);
  endtask
  // two back-to-back writes, frames decoded and their spacing measured
  task automatic tx_pair(input logic [7:0] f, input logic xb);
    logic [11:0] got, e0, e1;
    time t0, t1;
    int n, nd;
    fmt = f;
    txb = xb;
    nd = 5 + int'(f[3:2]);
    e0 = frm(f, 8'h35, f[4] ? par(8'h35, nd, f[6:5]) : xb, n);
    e1 = frm(f, 8'hcb, f[4] ? par(8'hcb, nd, f[6:5]) : xb, n);
    fork
      begin
        tx_wr_valid = 1'b1;
        tx_wr_data = 8'h35;
        @(negedge sys_clk);
        tx_wr_data = 8'hcb;
        @(negedge sys_clk);
        tx_wr_valid = 1'b0;
      end
      begin
        uft_peer_i.recv(n, got, t0);
        check("frame0", got, e0);
        uft_peer_i.recv(n, got, t1);
        check("frame1", got, e1);
        check("gap", 12'((t1 - t0) / 10),
              12'((n + 1) * uft_peer_i.bit_len));
      end
    join
    @(negedge sys_clk);
    check("done", flags.transmit_done_flag, 1'b1);
    clr();
    repeat (3 * uft_peer_i.bit_len) @(negedge sys_clk);
  endtask
  // every prescaler code sets the bit time
  task automatic prescale();
    for (int c = 0; c < 4; c++) begin
      baud = '{1'b1, 2'(c), 16'hfffe};
      uft_peer_i.bit_len = 4 * pdiv[c];
      tx_pair(8'h0c, 1'b0);
    end
    baud = '{1'b1, 2'h3, 16'hfff8};
    uft_peer_i.bit_len = 16;
  endtask
  // fill the send buffer while held, then drain it onto the line
  task automatic tx_fill();
    logic [11:0] got;
    time t;
    int n;
    baud.run = 1'b0;
    fmt = 8'h0c;
    tx_wr_valid = 1'b1;
    for (int k = 0; k < 8; k++) begin
      check("room", tx_wr_ready, 1'b1);
      tx_wr_data = 8'(2 * k + 1);
      @(negedge sys_clk);
    end
    tx_wr_data = 8'hff;
    check("full", tx_wr_ready, 1'b0);
    @(negedge sys_clk);
    tx_wr_valid = 1'b0;
    baud.run = 1'b1;
    for (int k = 0; k < 8; k++) begin
      uft_peer_i.recv(9, got, t);
      check("drain", got, frm(8'h0c, 8'(2 * k + 1), 1'b0, n));
    end
    repeat (40) @(negedge sys_clk);
    check("line", txl, 1'b1);
    clr();
  endtask
  // one frame in, then the stored byte and the flags
  task automatic rx_case(input logic [7:0] f, d, input logic b, rr, pe, xb);
    logic [11:0] v;
    int n;
    fmt = f;
    v = frm(f, d, b, n);
    uft_peer_i.send(v, n);
    repeat (4) @(negedge sys_clk);
    check("rr", flags.receive_ready_flag, rr);
    check("perr", flags.parity_error_flag, pe);
    check("rbx", rbx, xb);
    pop(d);
    clr();
    check("empty", rx_valid, 1'b0);
  endtask
  // four bytes into a three-deep buffer
  task automatic rx_overrun();
    logic [11:0] v;
    int n;
    fmt = 8'h0c;
    for (int k = 1; k < 5; k++) begin
      v = frm(8'h0c, 8'(k * 17), 1'b0, n);
      uft_peer_i.send(v, n);
    end
    repeat (4) @(negedge sys_clk);
    check("ovr", flags.overrun_flag, 1'b1);
    clr();
    check("rr hold", flags.receive_ready_flag, 1'b1);
    for (int k = 1; k < 4; k++) pop(8'(k * 17));
    check("left", rx_valid, 1'b0);
    clr();
  endtask
  // low stop bit, then receiver off, then on again
  task automatic rx_drop();
    logic [11:0] v;
    int n;
    v = frm(8'h0c, 8'h66, 1'b0, n);
    v[8] = 1'b0;
    uft_peer_i.send(v, n);
    ren = 1'b0;
    v[8] = 1'b1;
    uft_peer_i.send(v, n);
    repeat (4) @(negedge sys_clk);
    check("kept", rx_valid, 1'b0);
    check("flags", flags, 4'h0);
    ren = 1'b1;
    uft_peer_i.send(v, n);
    repeat (4) @(negedge sys_clk);
    pop(8'h66);
    clr();
  endtask
  // cut a hang short, far beyond the expected run time
  initial begin
    #400us;
    n_fail++;
    summarize();
  end
  initial begin
    {reset, ren, txb, tx_wr_valid, rx_rd} = 5'b11000;
    {fmt, tx_wr_data, flag_clr} = 20'h0c000;
    baud = '{1'b1, 2'h3, 16'hfff8};
    n_fail = 0;
    total_checks = 0;
    repeat (6) @(negedge sys_clk);
    reset = 1'b0;
    @(negedge sys_clk);
    foreach (txf[i]) tx_pair(txf[i], txx[i]);
    prescale();
    tx_fill();
    rx_case(8'h0c, 8'h5a, 1'b0, 1'b1, 1'b0, 1'b1);
    rx_case(8'h00, 8'h15, 1'b0, 1'b1, 1'b0, 1'b1);
    rx_case(8'h15, 8'h2d, 1'b0, 1'b1, 1'b1, 1'b1);
    rx_case(8'h38, 8'h47, 1'b0, 1'b1, 1'b0, 1'b1);
    rx_case(8'h1c, 8'h01, 1'b0, 1'b1, 1'b0, 1'b1);
    rx_case(8'h5c, 8'h81, 1'b1, 1'b1, 1'b0, 1'b1);
    rx_case(8'h7c, 8'ha5, 1'b1, 1'b1, 1'b1, 1'b1);
    rx_case(8'h0e, 8'hc3, 1'b0, 1'b1, 1'b0, 1'b0);
    rx_case(8'h8e, 8'h3c, 1'b0, 1'b0, 1'b0, 1'b0);
    rx_case(8'h8e, 8'h99, 1'b1, 1'b1, 1'b0, 1'b1);
    rx_overrun();
    rx_drop();
    summarize();
  end
endmodule
